// >>> design/qdac_pkg.sv
package qdac_pkg;
  // word layout, msb first
  localparam int WORD_BITS    = 16;
  localparam int DATA_BITS    = 10;
  localparam int CHANNELS     = 4;
  localparam int ADDR_HI_POS  = 15;
  localparam int ADDR_LO_POS  = 14;
  localparam int CTRL_HI_POS  = 13;
  localparam int CTRL_LO_POS  = 12;
  localparam int DATA_MSB_POS = 11;
  localparam int DATA_LSB_POS = 2;
  localparam int BIT_CNT_W    = 5;

  // address/control codes {addr_hi, addr_lo, ctrl_hi, ctrl_lo}
  localparam logic [3:0] CMD_NOP       = 4'h0;
  localparam logic [3:0] CMD_UPD_ALL   = 4'h4;
  localparam logic [3:0] CMD_LOAD_ALL  = 4'h8;
  localparam logic [3:0] CMD_SHUTDOWN  = 4'hc;
  localparam logic [3:0] CMD_ULO_LOW   = 4'h2;
  localparam logic [3:0] CMD_ULO_HIGH  = 4'h6;
  localparam logic [3:0] CMD_ECHO_RISE = 4'he;
  localparam logic [3:0] CMD_ECHO_FALL = 4'ha;
  localparam logic [1:0] CTRL_LOAD_IN  = 2'h1;
  localparam logic [1:0] CTRL_LOAD_UPD = 2'h3;

  localparam logic [9:0]  ZERO_CODE = 10'h000;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [2:0]  SYNC_ZERO = 3'h0;

  // one decoded command word
  typedef struct packed {
    logic [1:0] addr;
    logic [1:0] ctrl;
    logic [9:0] data;
    logic [1:0] sub;
  } qdac_word_type;

  // sampled serial pins
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic din;
    logic lockout_n;
    logic wipe_n;
  } qdac_pins_type;
endpackage

// >>> design/qdac_serial.sv
`timescale 1ns/1ns
// What this block does
// - command is 16 bits msb first, one 16-bit or two 8-bit transfers per frame
// - word is two address bits, two control bits, ten data bits, two sub-bits
// - control 01 loads addressed input register, dac registers unchanged
// - control 11 loads addressed input register then updates all dac registers
// - address 01 control 00 copies inputs to dacs and leaves shutdown
// - address 10 control 00 loads data into all inputs and dacs, leaves shutdown
// - address 11 control 00 enters shutdown only while lockout pin is high
// - code 0010 drives user output low, code 0110 drives it high
// - all-zero address and control is a no-operation
// - code 1110 selects echo on rising edge and updates all dacs
// - code 1010 selects echo on falling edge and updates all dacs
// - chip select high disables the interface, nothing shifted
// - chip select low shifts serial in on each rising serial clock
// - decode and register updates happen on chip select rising edge
// - echo is shift register far end, lag 16.5 or 16 clocks
// - after reset echo uses falling edge mode
// - shutdown command ignored while lockout pin is low
// - lockout falling edge wakes from shutdown without serial clock, except while wipe pin is low at that edge
// - devices chain echo to serial in, one word per device per frame
// - wipe pin low clears input, dac and shift registers, user output and echo
// - reset clears every input and dac register to zero
// - serial interface and input registers keep working in shutdown
module qdac_serial
  import qdac_pkg::*;
(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  // serial pins
  input  wire logic       i_sclk,
  input  wire logic       i_cs_n,
  input  wire logic       i_serial_in,
  output logic            o_serial_echo_out,
  // control pins
  input  wire logic       i_sleep_lockout_n,
  input  wire logic       i_async_wipe_n,
  output logic            o_user_logic_out,
  output logic            o_shutdown,
  output logic            o_echo_rise_mode,
  // converter codes
  output logic [9:0]      o_input_a,
  output logic [9:0]      o_input_b,
  output logic [9:0]      o_input_c,
  output logic [9:0]      o_input_d,
  output logic [9:0]      o_dac_a,
  output logic [9:0]      o_dac_b,
  output logic [9:0]      o_dac_c,
  output logic [9:0]      o_dac_d
);
  qdac_pins_type pins_raw, pins;
  logic          sclk_d_r, sclk_d_nxt;
  logic          cs_d_r, cs_d_nxt;
  logic          lock_d_r, lock_d_nxt;
  logic          sclk_rise, sclk_fall, cs_rise, lock_fall, wipe;
  logic [15:0]   shift_r, shift_nxt;
  logic          echo_r, echo_nxt;
  logic          spill_r, spill_nxt; // bit that left the far end at the last rise
  logic          ulo_r, ulo_nxt;
  logic          sd_r, sd_nxt;
  logic          mode_r, mode_nxt;
  logic [9:0]    in_r [CHANNELS];
  logic [9:0]    in_nxt [CHANNELS];
  logic [9:0]    dac_r [CHANNELS];
  logic [9:0]    dac_nxt [CHANNELS];
  qdac_word_type cmd;

  // gather pins for synchronising
  assign pins_raw = '{sclk: i_sclk, cs_n: i_cs_n, din: i_serial_in,
                      lockout_n: i_sleep_lockout_n, wipe_n: i_async_wipe_n};

  qdac_sync u_sync (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_pins  (pins_raw),
    .o_pins  (pins)
  );

  // edge detection on synchronised pins
  assign sclk_rise = pins.sclk & ~sclk_d_r;
  assign sclk_fall = ~pins.sclk & sclk_d_r;
  assign cs_rise   = pins.cs_n & ~cs_d_r;
  assign lock_fall = ~pins.lockout_n & lock_d_r;
  assign wipe      = ~pins.wipe_n;
  assign cmd       = qdac_word_type'(shift_r);

  // true when the code also refreshes every dac from its input register
  function automatic logic updates_all(input logic [3:0] code);
    updates_all = (code == CMD_UPD_ALL) || (code == CMD_ECHO_RISE) ||
                  (code == CMD_ECHO_FALL) || (code[1:0] == CTRL_LOAD_UPD);
  endfunction

  // edge history
  always_comb begin
    sclk_d_nxt = pins.sclk;
    cs_d_nxt   = pins.cs_n;
    lock_d_nxt = pins.lockout_n;
  end

  // shift register and echo
  always_comb begin
    shift_nxt = shift_r;
    echo_nxt  = echo_r;
    spill_nxt = spill_r;
    if (wipe) begin
      shift_nxt = ZERO_WORD;
      echo_nxt  = 1'b0;
      spill_nxt = 1'b0;
    end else if (!pins.cs_n) begin
      if (sclk_rise) begin
        // oldest bit falls off the far end, so long frames keep the last 16
        shift_nxt = {shift_r[WORD_BITS-2:0], pins.din};
        spill_nxt = shift_r[WORD_BITS-1];
        if (mode_r) begin
          echo_nxt = shift_r[WORD_BITS-1];
        end
      end else if (sclk_fall && !mode_r) begin
        // falling-edge mode shows the spilled bit half a clock later
        echo_nxt = spill_r;
      end
    end
  end

  // decode on chip select rising edge
  always_comb begin
    ulo_nxt  = ulo_r;
    sd_nxt   = sd_r;
    mode_nxt = mode_r;
    for (int i = 0; i < CHANNELS; i++) begin
      in_nxt[i]  = in_r[i];
      dac_nxt[i] = dac_r[i];
    end
    if (wipe) begin
      ulo_nxt = 1'b0;
      for (int i = 0; i < CHANNELS; i++) begin
        in_nxt[i]  = ZERO_CODE;
        dac_nxt[i] = ZERO_CODE;
      end
    end else begin
      if (lock_fall && sd_r) begin
        sd_nxt = 1'b0;
      end
      if (cs_rise) begin
        if (cmd.ctrl == CTRL_LOAD_IN || cmd.ctrl == CTRL_LOAD_UPD) begin
          in_nxt[cmd.addr] = cmd.data;
        end
        if (updates_all({cmd.addr, cmd.ctrl})) begin
          for (int i = 0; i < CHANNELS; i++) begin
            dac_nxt[i] = (i == int'(cmd.addr) && cmd.ctrl == CTRL_LOAD_UPD) ?
                         cmd.data : in_r[i];
          end
        end
        case ({cmd.addr, cmd.ctrl})
          CMD_UPD_ALL: begin
            sd_nxt = 1'b0;
          end
          CMD_LOAD_ALL: begin
            sd_nxt = 1'b0;
            for (int i = 0; i < CHANNELS; i++) begin
              in_nxt[i]  = cmd.data;
              dac_nxt[i] = cmd.data;
            end
          end
          CMD_SHUTDOWN: begin
            if (pins.lockout_n) begin
              sd_nxt = 1'b1;
            end
          end
          CMD_ULO_LOW: begin
            ulo_nxt = 1'b0;
          end
          CMD_ULO_HIGH: begin
            ulo_nxt = 1'b1;
          end
          CMD_ECHO_RISE: begin
            mode_nxt = 1'b1;
          end
          CMD_ECHO_FALL: begin
            mode_nxt = 1'b0;
          end
          CMD_NOP: begin
            sd_nxt = sd_nxt;
          end
          default: begin
            sd_nxt = sd_nxt;
          end
        endcase
      end
    end
  end

  // registers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sclk_d_r <= 1'b0;
      cs_d_r   <= 1'b1;
      lock_d_r <= 1'b1;
      shift_r  <= ZERO_WORD;
      echo_r   <= 1'b0;
      spill_r  <= 1'b0;
      ulo_r    <= 1'b0;
      sd_r     <= 1'b0;
      mode_r   <= 1'b0;
      for (int i = 0; i < CHANNELS; i++) begin
        in_r[i]  <= ZERO_CODE;
        dac_r[i] <= ZERO_CODE;
      end
    end else begin
      sclk_d_r <= sclk_d_nxt;
      cs_d_r   <= cs_d_nxt;
      lock_d_r <= lock_d_nxt;
      shift_r  <= shift_nxt;
      echo_r   <= echo_nxt;
      spill_r  <= spill_nxt;
      ulo_r    <= ulo_nxt;
      sd_r     <= sd_nxt;
      mode_r   <= mode_nxt;
      for (int i = 0; i < CHANNELS; i++) begin
        in_r[i]  <= in_nxt[i];
        dac_r[i] <= dac_nxt[i];
      end
    end
  end

  // outputs straight from flip-flops
  assign o_serial_echo_out = echo_r;
  assign o_user_logic_out  = ulo_r;
  assign o_shutdown        = sd_r;
  assign o_echo_rise_mode  = mode_r;
  assign o_input_a         = in_r[0];
  assign o_input_b         = in_r[1];
  assign o_input_c         = in_r[2];
  assign o_input_d         = in_r[3];
  assign o_dac_a           = dac_r[0];
  assign o_dac_b           = dac_r[1];
  assign o_dac_c           = dac_r[2];
  assign o_dac_d           = dac_r[3];
endmodule // qdac_serial

// >>> design/qdac_sync.sv
`timescale 1ns/1ns
// two-flop synchroniser for the serial pins
module qdac_sync
  import qdac_pkg::*;
(
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_reset,
  // pins
  input  wire qdac_pins_type i_pins,
  output qdac_pins_type      o_pins
);
  qdac_pins_type meta_r, meta_nxt, sync_r, sync_nxt;

  // idle value: strobes and lows inactive
  localparam qdac_pins_type IDLE = '{sclk: 1'b0, cs_n: 1'b1, din: 1'b0,
                                    lockout_n: 1'b1, wipe_n: 1'b1};

  // next state
  always_comb begin
    meta_nxt = i_pins;
    sync_nxt = meta_r;
  end

  // registers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      meta_r <= IDLE;
      sync_r <= IDLE;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign o_pins = sync_r;
endmodule // qdac_sync

// >>> tb/qdac_host_model.sv
`timescale 1ns/1ns
// serial master on the far side, sclk idles low between frames
module qdac_host_model (
  // echo sampling
  input  wire logic i_rise_mode,
  input  wire logic i_echo,
  // serial pins
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_din
);
  logic [15:0] echo_q;
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_din  = 1'b0;
    echo_q = 16'h0000;
  end
  // open a frame
  task automatic open_f();
    o_cs_n = 1'b0;
    #40;
  endtask
  // one word msb first at 125 ns per bit, optional pause after 8 bits
  task automatic xfer(input logic [15:0] w, input logic sp);
    for (int i = 15; i >= 0; i--) begin
      o_din = w[i];
      #20;
      o_sclk = 1'b1;
      #63;
      if (i_rise_mode) echo_q = {echo_q[14:0], i_echo};
      o_sclk = 1'b0;
      #42;
      if (!i_rise_mode) echo_q = {echo_q[14:0], i_echo};
      if (sp && i == 8) #300;
    end
  endtask
  // close after the last bit; released data line shows the inverse
  task automatic close_f();
    #62;
    o_cs_n = 1'b1;
    o_din  = ~o_din;
    #100;
  endtask
endmodule // qdac_host_model

// >>> tb/qdac_serial_monitor.sv
`timescale 1ns/1ns
// port checks for the serial command block
module qdac_serial_monitor (
  // clock, reset and pins
  input wire logic       i_clk, i_reset, i_sclk, i_cs_n, i_serial_in,
  input wire logic       i_sleep_lockout_n, i_async_wipe_n, o_serial_echo_out,
  input wire logic       o_user_logic_out, o_shutdown, o_echo_rise_mode,
  // converter codes
  input wire logic [9:0] o_input_a, o_input_b, o_input_c, o_input_d,
  input wire logic [9:0] o_dac_a, o_dac_b, o_dac_c, o_dac_d
);
  logic [4:0] sck_r, cs_r, wp_r, sck_nxt, cs_nxt, wp_nxt;
  logic       cs_rose, sck_rise, sck_fall, wp_quiet;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // pin history, bit k is the pin k+1 cycles back
  always_comb begin
    sck_nxt = {sck_r[3:0], i_sclk};
    cs_nxt  = {cs_r[3:0], i_cs_n};
    wp_nxt  = {wp_r[3:0], i_async_wipe_n};
  end
  always_ff @(posedge i_clk) begin
    sck_r <= sck_nxt;
    cs_r  <= cs_nxt;
    wp_r  <= wp_nxt;
  end
  // pin edges 2 to 4 cycles back, allowing for the synchroniser
  assign cs_rose  = |(cs_r[3:1] & ~cs_r[4:2]);
  assign sck_rise = |(sck_r[3:1] & ~sck_r[4:2]);
  assign sck_fall = |(~sck_r[3:1] & sck_r[4:2]);
  assign wp_quiet = &wp_r[3:0];
  sequence wipe_held; !i_async_wipe_n [*5]; endsequence
  sequence lock_held; !i_sleep_lockout_n [*6]; endsequence
  reset_clear_a :
    assert property ($fell(i_reset) |-> !(|{o_input_a, o_input_d, o_dac_a, o_dac_d,
      o_user_logic_out, o_shutdown, o_echo_rise_mode})) else $error("reset state wrong");
  wipe_clear_a :
    assert property (wipe_held |-> !(|{o_input_b, o_input_c, o_dac_b, o_dac_c,
      o_user_logic_out, o_serial_echo_out})) else $error("wipe did not clear");
  lock_wake_a :
    assert property ($fell(i_sleep_lockout_n) |-> ##[1:5] !o_shutdown) else $error("no wake");
  lock_block_a :
    assert property (lock_held |-> !o_shutdown) else $error("shutdown while locked");
  mode_at_cs_a :
    assert property ($changed(o_echo_rise_mode) |-> cs_rose) else $error("mode moved early");
  ulo_at_cs_a :
    assert property ($changed(o_user_logic_out) |-> cs_rose || !wp_quiet)
      else $error("user output moved early");
  dac_at_cs_a :
    assert property ($changed(o_dac_a) |-> cs_rose || !wp_quiet) else $error("dac moved");
  input_at_cs_a :
    assert property ($changed(o_input_b) |-> cs_rose || !wp_quiet) else $error("input moved");
  echo_edge_a :
    assert property ($changed(o_serial_echo_out) && wp_quiet |->
      (o_echo_rise_mode ? sck_rise : sck_fall)) else $error("echo on wrong edge");
endmodule // qdac_serial_monitor

bind qdac_serial qdac_serial_monitor mon (.*);

// >>> tb/qdac_serial_tb.sv
`timescale 1ns/1ns
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
  $display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end
// self-checking bench for the serial command block
module qdac_serial_tb;
  logic       i_clk = 1'b0, i_reset = 1'b1, i_sleep_lockout_n = 1'b1, i_async_wipe_n = 1'b1;
  logic       i_sclk, i_cs_n, i_serial_in, o_serial_echo_out, o_user_logic_out, o_shutdown;
  logic       o_echo_rise_mode, ulo_e, sd_e, m1_e, lk;
  logic [9:0] o_input_a, o_input_b, o_input_c, o_input_d, o_dac_a, o_dac_b, o_dac_c, o_dac_d;
  logic [9:0] in_e [4], dac_e [4];
  logic [15:0] w, p;
  int         errors = 0, num_checks = 0, seed = 32'h0cbfe575;
  qdac_serial dut (.*);
  qdac_host_model host (.i_rise_mode(m1_e), .i_echo(o_serial_echo_out), .o_sclk(i_sclk),
    .o_cs_n(i_cs_n), .o_din(i_serial_in));
  always #5 i_clk = ~i_clk;
  // expected effect of one decoded word
  function automatic void apply(input logic [15:0] c);
    case (c[15:12])
      4'h0: ;
      4'h4: begin dac_e = in_e; sd_e = 1'b0; end
      4'h8: begin in_e = '{4{c[11:2]}}; dac_e = in_e; sd_e = 1'b0; end
      4'hc: if (i_sleep_lockout_n) sd_e = 1'b1;
      4'h2: ulo_e = 1'b0;
      4'h6: ulo_e = 1'b1;
      4'he: begin m1_e = 1'b1; dac_e = in_e; end
      4'ha: begin m1_e = 1'b0; dac_e = in_e; end
      default: begin in_e[c[15:14]] = c[11:2]; if (c[13]) dac_e = in_e; end
    endcase
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic chk_all();
    `CHK({o_input_a, o_input_b, o_input_c, o_input_d}, {in_e[0], in_e[1], in_e[2], in_e[3]})
    `CHK({o_dac_a, o_dac_b, o_dac_c, o_dac_d}, {dac_e[0], dac_e[1], dac_e[2], dac_e[3]})
    `CHK({o_user_logic_out, o_shutdown, o_echo_rise_mode}, {ulo_e, sd_e, m1_e})
  endtask
  // one frame, optionally led by a chained word
  task automatic send(input logic [15:0] c, input logic [15:0] q, input logic dz, input logic sp);
    host.open_f();
    if (dz) host.xfer(q, 1'b0);
    host.xfer(c, sp);
    host.close_f();
    tick(2);
    apply(c);
    chk_all();
    if (dz) `CHK(host.echo_q, q)
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #900000;
    errors++;
    final_report();
  end
  // reset, every code at random, then lockout, wipe and a second reset
  initial begin
    in_e = '{4{10'h000}};
    dac_e = in_e;
    {ulo_e, sd_e, m1_e} = 3'h0;
    tick(20);
    i_reset = 1'b0;
    tick(5);
    chk_all();
    for (int i = 0; i < 48; i++) begin
      w = $random(seed);
      p = $random(seed);
      lk = $random(seed);
      if (i < 16) w[15:12] = i[3:0];
      w[1:0] = 2'h0;
      if (i_sleep_lockout_n && !lk) sd_e = 1'b0;
      i_sleep_lockout_n = lk;
      tick(6);
      send(w, p, i[0], i[1]);
      $display("test %0d code %h done", i, w[15:12]);
    end
    i_sleep_lockout_n = 1'b1;
    tick(6);
    send(16'hc000, 16'h0000, 1'b0, 1'b0);
    i_sleep_lockout_n = 1'b0;
    sd_e = 1'b0;
    tick(6);
    chk_all();
    send(16'hc000, 16'h0000, 1'b0, 1'b1);
    i_async_wipe_n = 1'b0;
    tick(6);
    in_e = '{4{10'h000}};
    dac_e = in_e;
    ulo_e = 1'b0;
    chk_all();
    `CHK(o_serial_echo_out, 1'b0)
    i_async_wipe_n = 1'b1;
    i_reset = 1'b1;
    tick(20);
    i_reset = 1'b0;
    {sd_e, m1_e} = 2'h0;
    tick(5);
    chk_all();
    $display("test final done");
    final_report();
  end
endmodule // qdac_serial_tb
